// File: design/sweep_pkg.sv
package sweep_pkg;

    // ****************************************************************
    // Register map (word offsets on the plain register port)
    // ****************************************************************
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_START = 4'h1;
    localparam logic [3:0] REG_STOP = 4'h2;
    localparam logic [3:0] REG_CENTER = 4'h3;
    localparam logic [3:0] REG_SPAN = 4'h4;
    localparam logic [3:0] REG_MARKER = 4'h5;
    localparam logic [3:0] REG_TIME = 4'h6;
    localparam logic [3:0] REG_STATUS = 4'h7;
    localparam logic [3:0] REG_FREQ = 4'h8;
    localparam logic [3:0] REG_TRIG = 4'h9;

    // ****************************************************************
    // Control field positions
    // ****************************************************************
    localparam int CTL_SWEEP_EN = 0;
    localparam int CTL_BURST_EN = 1;
    localparam int CTL_MOD_EN = 2;
    localparam int CTL_LOG = 3;
    localparam int CTL_MARKER_EN = 4;
    localparam int CTL_SYNC_EN = 5;
    localparam int CTL_TOUT_EN = 6;
    localparam int CTL_TOUT_FALL = 7;
    localparam int CTL_TRIG_FALL = 8;
    localparam int CTL_SRC_LO = 9;
    localparam int CTL_WAVE_LO = 11;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0020;

    // ****************************************************************
    // Frequencies in tenths of a hertz, times in microseconds
    // ****************************************************************
    // Tenths keep the full 80 MHz bound inside a 32-bit word
    localparam logic [31:0] FREQ_MAX_MHZ = 32'h2faf_0800; // 80 MHz
    localparam logic [31:0] FREQ_MAX_RAMP = 32'h0098_9680; // 1 MHz
    localparam logic [31:0] FREQ_MAX_ARB = 32'h0ee6_b280; // 25 MHz
    localparam logic [31:0] START_RESET = 32'h0000_03e8; // 100 Hz
    localparam logic [31:0] STOP_RESET = 32'h0000_2710; // 1 kHz
    localparam logic [31:0] CENTER_RESET = 32'h0000_157c; // 550 Hz
    localparam logic [31:0] MARKER_RESET = 32'h0000_1388; // 500 Hz
    localparam logic [31:0] TIME_MIN_US = 32'h0000_03e8; // 1 ms
    localparam logic [31:0] TIME_MAX_US = 32'h1dcd_6500; // 500 s
    localparam logic [31:0] TIME_RESET_US = 32'h000f_4240; // 1 s

    localparam int CLK_MHZ = 125;
    localparam logic [7:0] TICK_CYC = 8'(CLK_MHZ - 1); // 1 us tick
    localparam int TOUT_PULSE_NS = 2000;
    localparam logic [7:0] TOUT_PULSE_US = 8'(TOUT_PULSE_NS / 1000);

    typedef enum logic [1:0] {SRC_INT, SRC_EXT, SRC_MAN} src_t;
    typedef enum logic [2:0] {
        W_SINE, W_SQUARE, W_RAMP, W_ARB, W_PULSE, W_NOISE, W_DC
    } wave_t;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HOLD} sweep_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : sweep_pkg

// File: design/sweep_seq.sv
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Contract
// RULE1: Enabling sweep turns off burst and modulation modes.
// RULE2: Sweep refused for pulse, noise and dc waveforms.
// RULE3: Sweep runs start to stop, then returns to start.
// RULE4: Phase continuous; bounds limited 80 MHz, ramp 1 MHz, arb 25 MHz.
// RULE5: Start below stop sweeps up; start above stop sweeps down.
// RULE6: Start defaults to 100 Hz, stop to 1 kHz.
// RULE7: Center (550 Hz) and signed span may set the bounds.
// RULE8: Linear or logarithmic spacing, linear by default.
// RULE9: Sweep time 1 ms to 500 s, default 1 s; steps derived.
// RULE10: Marker off: sync is 50% square, period equals sweep time.
// RULE11: Marker on: sync high at start, low at marker frequency. Code keeps sync low after the first sweep under internal source.
// RULE12: Marker outside bounds is clamped to nearer bound; default 500 Hz.
// RULE13: Marker with sweep overrides the sync on/off setting.
// RULE14: Triggered: one sweep per trigger, then hold start frequency.
// RULE15: Source internal, external or manual; internal repeats continuously.
// RULE16: External: one sweep per selected edge of trigger input.
// RULE17: External trigger spacing at least sweep time plus 1 ms.
// RULE18: Manual key launches one sweep under manual or external source.
// RULE19: Trigger-out edge at sweep start, polarity selectable.
// RULE20: Internal source: trigger-out 50% square of sweep period.
// RULE21: External source disables trigger-out.
// RULE22: Manual source: trigger-out pulse wider than 1 us.
module sweep_seq
    import sweep_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire reg_req_t req,
    output logic [31:0] rdata,
    input wire logic trig_in,
    input wire logic man_key,
    output logic sync_out,
    output logic trig_out,
    output logic trig_out_oe_b,
    output logic [31:0] freq_word
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] clamp(input logic [31:0] v,
                                          input logic [31:0] lim);
        clamp = (v > lim) ? lim : v;
    endfunction : clamp

    function automatic logic [31:0] fmax(input logic [2:0] w);
        if (w == W_RAMP)
            fmax = FREQ_MAX_RAMP;
        else if (w == W_ARB)
            fmax = FREQ_MAX_ARB;
        else
            fmax = FREQ_MAX_MHZ;
    endfunction : fmax

    logic [31:0] ctrl_q, start_q, stop_q, marker_q, time_q, center_q;
    logic [31:0] span_q;
    sweep_state_t state_q;
    logic [31:0] freq_q, elapsed_q;
    logic [7:0] tick_cnt_q, pulse_q;
    logic trig_d1_q, key_d1_q, marker_hit_q, tout_q, sync_q;
    logic tick, sweep_ok, launch, ext_edge, key_edge, sweep_done;
    logic [31:0] lo, hi, mark_eff, lim, step_lin, step_log;
    logic [1:0] src;
    logic up;

    assign src = ctrl_q[CTL_SRC_LO+:2];
    assign lim = fmax(ctrl_q[CTL_WAVE_LO+:3]);
    assign sweep_ok = ctrl_q[CTL_SWEEP_EN] &&
        (ctrl_q[CTL_WAVE_LO+:3] <= 3'(W_ARB)); // [RULE2]
    assign up = (start_q <= stop_q); // [RULE5]
    assign lo = up ? start_q : stop_q;
    assign hi = up ? stop_q : start_q;
    assign mark_eff = (marker_q < lo) ? lo :
        ((marker_q > hi) ? hi : marker_q); // [RULE12]

    // ****************************************************************
    // Register writes
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_q <= CTRL_RESET;
            start_q <= START_RESET; // [RULE6]
            stop_q <= STOP_RESET; // [RULE6]
            center_q <= CENTER_RESET;
            span_q <= STOP_RESET - START_RESET;
            marker_q <= MARKER_RESET;
            time_q <= TIME_RESET_US; // [RULE9]
        end
        else if (req.wr)
        begin
            if (req.addr == REG_CTRL)
            begin
                ctrl_q <= req.wdata;
                if (req.wdata[CTL_SWEEP_EN])
                begin
                    ctrl_q[CTL_BURST_EN] <= 1'b0; // [RULE1]
                    ctrl_q[CTL_MOD_EN] <= 1'b0; // [RULE1]
                end
            end
            else if (req.addr == REG_START)
                start_q <= clamp(req.wdata, lim); // [RULE4]
            else if (req.addr == REG_STOP)
                stop_q <= clamp(req.wdata, lim); // [RULE4]
            else if (req.addr == REG_CENTER || req.addr == REG_SPAN)
            begin
                // Signed span: negative swaps the bounds [RULE7]
                logic [31:0] c, s, half;
                c = (req.addr == REG_CENTER) ? clamp(req.wdata, lim) :
                    center_q;
                s = (req.addr == REG_SPAN) ? req.wdata : span_q;
                half = s[31] ? ((~s + 32'h1) >> 1) : (s >> 1);
                center_q <= c;
                span_q <= s;
                if (half > c)
                    half = c;
                start_q <= s[31] ? clamp(c + half, lim) : c - half;
                stop_q <= s[31] ? c - half : clamp(c + half, lim);
            end
            else if (req.addr == REG_MARKER)
                marker_q <= clamp(req.wdata, lim);
            else if (req.addr == REG_TIME)
                time_q <= (req.wdata < TIME_MIN_US) ? TIME_MIN_US :
                    clamp(req.wdata, TIME_MAX_US); // [RULE9]
        end
    end

    // ****************************************************************
    // Register reads, data one cycle after the strobe
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= 32'h0;
        else if (req.rd)
        begin
            if (req.addr == REG_CTRL)
                rdata <= ctrl_q;
            else if (req.addr == REG_START)
                rdata <= start_q;
            else if (req.addr == REG_STOP)
                rdata <= stop_q;
            else if (req.addr == REG_CENTER)
                rdata <= center_q;
            else if (req.addr == REG_SPAN)
                rdata <= span_q;
            else if (req.addr == REG_MARKER)
                rdata <= mark_eff;
            else if (req.addr == REG_TIME)
                rdata <= time_q;
            else if (req.addr == REG_STATUS)
                rdata <= {29'h0, sweep_ok, 2'(state_q)};
            else if (req.addr == REG_FREQ)
                rdata <= freq_q;
            else
                rdata <= 32'h0;
        end
        else
            rdata <= 32'h0;
    end

    // ****************************************************************
    // Trigger detection
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            trig_d1_q <= 1'b0;
            key_d1_q <= 1'b0;
        end
        else
        begin
            trig_d1_q <= trig_in;
            key_d1_q <= man_key;
        end
    end

    assign ext_edge = (src == 2'(SRC_EXT)) && (ctrl_q[CTL_TRIG_FALL] ?
        (trig_d1_q && !trig_in) : (!trig_d1_q && trig_in)); // [RULE16]
    // Key is honoured under manual or external source [RULE18]
    assign key_edge = man_key && !key_d1_q && (src != 2'(SRC_INT));
    // Bus write to the trigger register acts like the key, but only under manual source
    assign launch = ext_edge || key_edge ||
        (req.wr && req.addr == REG_TRIG && src == 2'(SRC_MAN));

    // ****************************************************************
    // Sweep timing, 1 us ticks
    // ****************************************************************
    assign tick = (tick_cnt_q == TICK_CYC);
    // Restart the microsecond at each sweep start, so the first point
    // lasts a full step and the trigger-out pulse has a fixed width
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            tick_cnt_q <= 8'h0;
        else if (tick || (sweep_ok && state_q != ST_RUN &&
            (src == 2'(SRC_INT) || launch)))
            tick_cnt_q <= 8'h0;
        else
            tick_cnt_q <= tick_cnt_q + 8'h1;
    end

    // One frequency point per microsecond: points = sweep time [RULE9]
    assign sweep_done = tick && (elapsed_q >= time_q - 32'h1);
    assign step_lin = ((hi - lo) / time_q) + 32'h1;
    // Log spacing: constant ratio step approximated per tick [RULE8]
    assign step_log = (freq_q >> 12) + 32'h1;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= ST_IDLE;
            elapsed_q <= 32'h0;
            freq_q <= START_RESET;
        end
        else if (!sweep_ok)
        begin
            state_q <= ST_IDLE;
            elapsed_q <= 32'h0;
            freq_q <= start_q;
        end
        else
        begin
            case (state_q)
                ST_IDLE, ST_HOLD:
                begin
                    freq_q <= start_q; // [RULE14]
                    elapsed_q <= 32'h0;
                    if (src == 2'(SRC_INT) || launch) // [RULE15]
                        state_q <= ST_RUN;
                end
                ST_RUN:
                begin
                    if (sweep_done)
                    begin
                        elapsed_q <= 32'h0;
                        freq_q <= start_q; // [RULE3]
                        state_q <= (src == 2'(SRC_INT)) ? ST_RUN :
                            ST_HOLD; // [RULE14]
                    end
                    else if (tick)
                    begin
                        logic [31:0] st;
                        st = ctrl_q[CTL_LOG] ? step_log : step_lin;
                        elapsed_q <= elapsed_q + 32'h1;
                        // Only the word moves; phase is kept by the
                        // accumulator downstream [RULE4]
                        if (up)
                            freq_q <= (hi - freq_q < st) ? hi :
                                freq_q + st; // [RULE5]
                        else
                            freq_q <= (freq_q - lo < st) ? lo :
                                freq_q - st;
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end
    assign freq_word = freq_q;

    // ****************************************************************
    // Sync and trigger-out
    // ****************************************************************
    logic start_pulse;
    assign start_pulse = (state_q != ST_RUN || sweep_done) &&
        sweep_ok && (src == 2'(SRC_INT) || launch || sweep_done);

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            marker_hit_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else if (state_q != ST_RUN)
        begin
            marker_hit_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            if (up ? (freq_q >= mark_eff) : (freq_q <= mark_eff))
                marker_hit_q <= 1'b1; // [RULE11]
            if (ctrl_q[CTL_MARKER_EN])
                sync_q <= !marker_hit_q; // [RULE11] [RULE13]
            else
                sync_q <= (elapsed_q < (time_q >> 1)); // [RULE10]
        end
    end
    assign sync_out = sync_q &&
        (ctrl_q[CTL_MARKER_EN] || ctrl_q[CTL_SYNC_EN]); // [RULE13]

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tout_q <= 1'b0;
            pulse_q <= 8'h0;
        end
        else if (src == 2'(SRC_INT))
        begin
            pulse_q <= 8'h0;
            tout_q <= (state_q == ST_RUN) &&
                (elapsed_q < (time_q >> 1)); // [RULE20]
        end
        else if (start_pulse && state_q != ST_RUN)
        begin
            pulse_q <= TOUT_PULSE_US; // [RULE22]
            tout_q <= 1'b1;
        end
        else if (tick && pulse_q != 8'h0)
        begin
            pulse_q <= pulse_q - 8'h1;
            tout_q <= (pulse_q != 8'h1);
        end
    end

    // Same connector is the trigger input when external [RULE21]
    assign trig_out_oe_b = !(ctrl_q[CTL_TOUT_EN] && sweep_ok &&
        src != 2'(SRC_EXT));
    assign trig_out = tout_q ^ ctrl_q[CTL_TOUT_FALL]; // [RULE19]

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_sweep_excl: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ctrl_q[CTL_SWEEP_EN] |-> !ctrl_q[CTL_BURST_EN] &&
            !ctrl_q[CTL_MOD_EN]) // [RULE1]
        else $error("sweep active with burst or modulation");
    a_wave_refuse: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ctrl_q[CTL_WAVE_LO+:3] > 3'(W_ARB) |=> state_q == ST_IDLE) // [RULE2]
        else $error("sweep ran with a forbidden waveform");
    a_hold_start: assert property (@(posedge ref_clk) disable iff (!rst_b)
        state_q == ST_HOLD && !launch && sweep_ok |=>
            freq_q == $past(start_q)) // [RULE14]
        else $error("hold does not output start frequency");
    a_ext_toff: assert property (@(posedge ref_clk) disable iff (!rst_b)
        src == 2'(SRC_EXT) |-> trig_out_oe_b) // [RULE21]
        else $error("trigger-out driven under external source");
    a_freq_bound: assert property (@(posedge ref_clk) disable iff (!rst_b)
        state_q == ST_RUN && $stable(start_q) && $stable(stop_q) |=>
            freq_q >= lo && freq_q <= hi) // [RULE3]
        else $error("frequency outside sweep bounds");
    a_marker_clamp: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        mark_eff >= lo && mark_eff <= hi) // [RULE12]
        else $error("marker not clamped");
    a_int_restart: assert property (@(posedge ref_clk) disable iff (!rst_b)
        sweep_ok && src == 2'(SRC_INT) && state_q == ST_RUN && sweep_done
            |=> state_q == ST_RUN && elapsed_q == 32'h0) // [RULE15]
        else $error("internal source did not repeat");
    a_time_range: assert property (@(posedge ref_clk) disable iff (!rst_b)
        time_q >= TIME_MIN_US && time_q <= TIME_MAX_US) // [RULE9]
        else $error("sweep time out of range");

endmodule : sweep_seq

// File: verif/ext_instr.sv
`timescale 1ns/1ps
module ext_instr #(
    parameter int MIN_GAP_CYC = 250000,
    parameter int HOLD_CYC = 10
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic fall,
    input wire logic fire,
    input wire logic press,
    output logic trig_in,
    output logic man_key
);
    int gap_q;
    int pulse_q;
    int key_q;

    // Idle level sits opposite the active edge, so a pulse gives one edge
    assign trig_in = fall ^ (pulse_q != 0);
    assign man_key = (key_q != 0);

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            gap_q <= MIN_GAP_CYC;
            pulse_q <= 0;
            key_q <= 0;
        end
        else
        begin
            // A request that comes too soon is dropped, never sent early
            if (fire && gap_q >= MIN_GAP_CYC)
            begin
                pulse_q <= HOLD_CYC;
                gap_q <= 0;
            end
            else
            begin
                pulse_q <= (pulse_q != 0) ? pulse_q - 1 : 0;
                gap_q <= (gap_q < MIN_GAP_CYC) ? gap_q + 1 : gap_q;
            end
            key_q <= press ? HOLD_CYC : ((key_q != 0) ? key_q - 1 : 0);
        end
    end
endmodule : ext_instr

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import sweep_pkg::*;
    localparam logic [31:0] SW = 32'h1 << CTL_SWEEP_EN;
    localparam logic [31:0] BU = 32'h1 << CTL_BURST_EN;
    localparam logic [31:0] MO = 32'h1 << CTL_MOD_EN;
    localparam logic [31:0] LG = 32'h1 << CTL_LOG;
    localparam logic [31:0] MK = 32'h1 << CTL_MARKER_EN;
    localparam logic [31:0] SY = 32'h1 << CTL_SYNC_EN;
    localparam logic [31:0] TO = 32'h1 << CTL_TOUT_EN;
    localparam logic [31:0] TF = 32'h1 << CTL_TOUT_FALL;
    localparam logic [31:0] GF = 32'h1 << CTL_TRIG_FALL;
    localparam logic [31:0] EXT = 32'h1 << CTL_SRC_LO;
    localparam logic [31:0] MAN = 32'h2 << CTL_SRC_LO;
    localparam logic [31:0] SPN = 32'h0000_07d0;
    localparam logic [31:0] MKF = START_RESET + 32'h0000_005a;
    localparam int US = 125;

    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    reg_req_t req = '0;
    logic [31:0] rdata;
    logic [31:0] freq_word;
    logic sync_out;
    logic trig_out;
    logic trig_out_oe_b;
    logic trig_in;
    logic man_key;
    logic fall = 1'b0;
    logic fire = 1'b0;
    logic press = 1'b0;
    logic rd_pend = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] rs;
    wave_t wv [3] = '{W_SINE, W_RAMP, W_ARB};
    logic [31:0] lim [3] = '{FREQ_MAX_MHZ, FREQ_MAX_RAMP, FREQ_MAX_ARB};
    int mismatches = 0;
    int total_checks = 0;

    sweep_seq dut (.ref_clk(ref_clk), .rst_b(rst_b), .req(req),
        .rdata(rdata), .trig_in(trig_in), .man_key(man_key),
        .sync_out(sync_out), .trig_out(trig_out),
        .trig_out_oe_b(trig_out_oe_b), .freq_word(freq_word));
    ext_instr far_end (.ref_clk(ref_clk), .rst_b(rst_b), .fall(fall),
        .fire(fire), .press(press), .trig_in(trig_in), .man_key(man_key));

    initial
    begin
        forever #4 ref_clk = ~ref_clk;
    end

    // ****************************************************************
    // Checking
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] got);
        total_checks++;
        if (got !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, e, got);
        end
    endtask : chk

    task automatic results;
        if (mismatches == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    // Read data stand only in the cycle after the strobe
    always @(posedge ref_clk)
    begin
        if (rd_pend)
            chk("rdata", exp_q.pop_front(), rdata);
        rd_pend <= req.rd;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        @(posedge ref_clk);
        req.rd <= 1'b0;
    endtask : rd

    task automatic key;
        @(posedge ref_clk);
        press <= 1'b1;
        @(posedge ref_clk);
        press <= 1'b0;
    endtask : key

    initial
    begin
        repeat (100000) @(posedge ref_clk);
        mismatches++;
        results();
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial
    begin
        void'($urandom(32'h59b35b9f));
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        cyc(1);
        chk("freq_word", START_RESET, freq_word);
        rd(REG_CTRL, CTRL_RESET);
        rd(REG_START, START_RESET);
        rd(REG_STOP, STOP_RESET);
        rd(REG_CENTER, CENTER_RESET);
        rd(REG_MARKER, MARKER_RESET);
        rd(REG_TIME, TIME_RESET_US);
        rd(4'hf, 32'h0);
        wr(REG_CTRL, SW | BU | MO);
        rd(REG_CTRL, SW);
        wr(REG_CTRL, SY);
        rs = $urandom_range(FREQ_MAX_MHZ, 1);
        wr(REG_START, rs);
        rd(REG_START, rs);
        for (int i = 0; i < 3; i++)
        begin
            wr(REG_CTRL, SY | (32'(wv[i]) << CTL_WAVE_LO));
            wr(REG_START, 32'hffff_ffff);
            rd(REG_START, lim[i]);
        end
        wr(REG_CTRL, SY);
        wr(REG_TIME, 32'h0000_0005);
        rd(REG_TIME, TIME_MIN_US);
        wr(REG_TIME, 32'hffff_ffff);
        rd(REG_TIME, TIME_MAX_US);
        wr(REG_TIME, TIME_MIN_US);
        wr(REG_SPAN, SPN);
        rd(REG_START, CENTER_RESET - SPN / 2);
        wr(REG_SPAN, -SPN);
        rd(REG_START, CENTER_RESET + SPN / 2);
        rd(REG_STOP, CENTER_RESET - SPN / 2);
        wr(REG_START, START_RESET);
        wr(REG_STOP, STOP_RESET);
        for (int i = 4; i < 7; i++)
        begin
            wr(REG_CTRL, SY);
            wr(REG_CTRL, SW | MAN | (32'(i) << CTL_WAVE_LO));
            wr(REG_TRIG, 32'h1);
            cyc(5 * US);
            chk("freq refused", START_RESET, freq_word);
            rd(REG_STATUS, 32'h0);
        end
        wr(REG_CTRL, SY);
        wr(REG_CTRL, SW | MK | TO | MAN);
        wr(REG_MARKER, 32'h0);
        rd(REG_MARKER, START_RESET);
        wr(REG_MARKER, 32'hffff_ffff);
        rd(REG_MARKER, STOP_RESET);
        wr(REG_MARKER, MKF);
        rd(REG_STATUS, 32'h0000_0004);
        wr(REG_TRIG, 32'h1);
        cyc(3);
        chk("freq_word", START_RESET, freq_word);
        chk("sync_out", 1, sync_out);
        chk("trig_out_oe_b", 0, trig_out_oe_b);
        chk("trig_out", 1, trig_out);
        cyc(US + US / 2);
        chk("trig_out", 1, trig_out);
        cyc(2 * US);
        chk("trig_out", 0, trig_out);
        cyc(16 * US);
        chk("sync_out", 0, sync_out);
        chk("freq linear", 1, 32'(freq_word > MKF));
        wr(REG_CTRL, SY);
        wr(REG_CTRL, SW | LG | EXT);
        key();
        cyc(20 * US);
        chk("freq log", 1, 32'(freq_word > START_RESET));
        chk("freq log", 1, 32'(freq_word < MKF));
        wr(REG_CTRL, SY);
        wr(REG_START, STOP_RESET);
        wr(REG_STOP, START_RESET);
        wr(REG_CTRL, SW | TO | TF | MAN);
        key();
        cyc(US / 2);
        chk("freq_word", STOP_RESET, freq_word);
        chk("trig_out", 0, trig_out);
        cyc(20 * US);
        chk("freq down", 1, 32'(freq_word < STOP_RESET));
        wr(REG_CTRL, SY);
        wr(REG_START, START_RESET);
        wr(REG_STOP, STOP_RESET);
        wr(REG_CTRL, SW | TO | GF | EXT);
        @(posedge ref_clk);
        fall <= 1'b1;
        cyc(20 * US);
        chk("trig_out_oe_b", 1, trig_out_oe_b);
        chk("freq idle", START_RESET, freq_word);
        @(posedge ref_clk);
        fire <= 1'b1;
        @(posedge ref_clk);
        fire <= 1'b0;
        cyc(20 * US);
        chk("freq ext", 1, 32'(freq_word > START_RESET));
        wr(REG_CTRL, SY);
        wr(REG_CTRL, SW | SY | TO);
        cyc(3);
        chk("sync_out", 1, sync_out);
        chk("trig_out", 1, trig_out);
        chk("trig_out_oe_b", 0, trig_out_oe_b);
        cyc(490 * US);
        chk("sync_out", 1, sync_out);
        chk("trig_out", 1, trig_out);
        cyc(20 * US);
        chk("sync_out", 0, sync_out);
        chk("trig_out", 0, trig_out);
        results();
    end
endmodule : tb_top
